/* File: ldio_pkg.sv */
// ldio_pkg: constants and carriers for the logical device configuration bank and i/o decoder
package ldio_pkg;
   // ****************************************
   // configuration indexes
   // ****************************************
   localparam logic [7:0] IDX_LDN = 8'h07; // logical device number
   localparam logic [7:0] IDX_ACT = 8'h30; // activate
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_DMA = 8'h74;
   localparam logic [7:0] IDX_DMA_UNUSED = 8'h75;
   localparam logic [7:0] IDX_VEND_LO = 8'he0;
   localparam logic [7:0] IDX_VEND_HI = 8'hfe;
   localparam logic [7:0] IDX_FINAL_RSVD = 8'hff;
   // ****************************************
   // logical device numbers
   // ****************************************
   localparam logic [3:0] LD_FLOPPY = 4'h0;
   localparam logic [3:0] LD_PARPORT = 4'h3;
   localparam logic [3:0] LD_SER1 = 4'h4;
   localparam logic [3:0] LD_SER2 = 4'h5;
   localparam logic [3:0] LD_KBD = 4'h7;
   localparam logic [3:0] LD_GAME = 4'h9;
   localparam int NUM_LD = 16;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_IRQ_LD0 = 8'h06;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [7:0] RST_DMA_LD0 = 8'h02;
   localparam logic [7:0] RST_DMA_OTHER = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam int ACT_BIT = 0;
   localparam int DMA_FIELD_W = 3;
   // ****************************************
   // address ranges
   // ****************************************
   localparam logic [11:0] BASE_MIN = 12'h100;
   localparam logic [11:0] BASE_MAX_8 = 12'hff8;
   localparam logic [11:0] BASE_MAX_4 = 12'hffc;
   localparam logic [11:0] BASE_MAX_1 = 12'hfff;
   localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
   localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
   localparam logic [11:0] ECP_OFFSET = 12'h400;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic wr;         // one-cycle write strobe
      logic rd;         // one-cycle read strobe
      logic [7:0] idx;  // configuration index
      logic [7:0] data; // write data
   } ldio_cfg_req_t;
   typedef struct packed {
      logic rd;          // io read cycle
      logic wr;          // io write cycle
      logic [15:0] addr; // io address
   } ldio_io_req_t;
endpackage : ldio_pkg

/* File: ldio_decode.sv */
// ldio_decode: combinational base-address check and i/o address match for one device
module ldio_decode (
   // device identity and programming
   input wire logic [3:0] ld_num,
   input wire logic [15:0] base,
   input wire logic active,
   input wire logic ecp_mode,
   input wire logic qual16,
   // io address
   input wire logic [15:0] addr,
   // results
   output logic base_ok,
   output logic hit
);
   logic [11:0] b; // decoded base bits
   logic [11:0] a; // decoded address bits
   logic [11:0] off; // address minus base
   logic upper_ok; // a15..a12 qualification
   assign b = base[11:0];
   assign a = addr[11:0];
   assign off = a - b;
   assign upper_ok = !qual16 || (addr[15:12] == 4'h0);
   // range check per device, alignment included
   always_comb begin
      base_ok = 1'b0;
      hit = 1'b0;
      unique case (ld_num)
         ldio_pkg::LD_FLOPPY, ldio_pkg::LD_SER1, ldio_pkg::LD_SER2: begin
            base_ok = (b >= ldio_pkg::BASE_MIN) && (b <= ldio_pkg::BASE_MAX_8)
                      && (b[2:0] == 3'h0);
            hit = (a[11:3] == b[11:3]);
         end
         ldio_pkg::LD_PARPORT: begin
            base_ok = (b >= ldio_pkg::BASE_MIN) && (b <= ldio_pkg::BASE_MAX_4)
                      && (b[1:0] == 2'h0);
            // +0..+2 always, +3..+7 only on 8-byte base
            hit = (off < 12'h003) || ((off < 12'h008) && (b[2:0] == 3'h0));
            // ecp block at +400h..+402h
            if (ecp_mode && (a - (b + ldio_pkg::ECP_OFFSET)) < 12'h003) begin
               hit = 1'b1;
            end
         end
         ldio_pkg::LD_KBD: begin
            base_ok = 1'b1; // fixed, not relocatable
            hit = (a == ldio_pkg::KBD_DATA_ADDR) || (a == ldio_pkg::KBD_CMD_ADDR);
         end
         ldio_pkg::LD_GAME: begin
            base_ok = (b >= ldio_pkg::BASE_MIN) && (b <= ldio_pkg::BASE_MAX_1);
            hit = (a == b);
         end
         default: begin
            base_ok = 1'b0;
            hit = 1'b0;
         end
      endcase
      // invalid base: claim nothing
      hit = hit && base_ok && active && upper_ok;
   end
endmodule : ldio_decode

/* File: ldio_bank.sv */
// ldio_bank: per-logical-device configuration registers with i/o claim outputs
// Functional notes
// - dma select only for floppy, parallel
// - index 75h discards writes, reads zero
// - 76h-dfh unimplemented, reads zero
// - e0h-feh vendor space, ffh reserved
// - device on when activate set
// - activate and power bits move together
// - invalid base: no claim, no action
// - interrupt select resets 06h for device 0
// - dma resets 02h dev0, 04h dev 3,5
// - defaults load on every reset source
// - parallel 4-byte base, epp needs 8
// - keyboard fixed at 60h and 64h
// - game port any base from 100h, one register
// - ldn register at 07h selects bank
// - bank reachable only in config state
// - 60h/61h hold base high/low
// - bits 11:0 decoded; 15:12 when qualified
module ldio_bank (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // any of power-on, bus or soft reset, one cycle pulse
   input wire logic soft_reset,
   // configuration port
   input wire ldio_pkg::ldio_cfg_req_t cfg,
   input wire logic cfg_state,
   input wire logic qual16,
   // io cycles and per-device controls
   input wire ldio_pkg::ldio_io_req_t io,
   input wire logic ecp_mode,
   // outputs
   output logic [7:0] cfg_rdata_ff,
   output logic [3:0] ldn_ff,
   output logic [15:0] dev_on_ff,
   output logic [15:0] io_claim_ff
);
   // ****************************************
   // bank storage
   // ****************************************
   logic [15:0] act_ff; // activate / power bit per device
   logic [7:0] base_hi_ff [ldio_pkg::NUM_LD];
   logic [7:0] base_lo_ff [ldio_pkg::NUM_LD];
   logic [7:0] irq_ff [ldio_pkg::NUM_LD];
   logic [7:0] dma_ff [ldio_pkg::NUM_LD];
   // ****************************************
   // access decode
   // ****************************************
   wire cfg_wr = cfg.wr && cfg_state;
   wire cfg_rd = cfg.rd && cfg_state;
   wire has_dma = (ldn_ff == ldio_pkg::LD_FLOPPY) || (ldn_ff == ldio_pkg::LD_PARPORT);
   wire wr_act = cfg_wr && (cfg.idx == ldio_pkg::IDX_ACT);
   wire wr_bhi = cfg_wr && (cfg.idx == ldio_pkg::IDX_BASE_HI);
   wire wr_blo = cfg_wr && (cfg.idx == ldio_pkg::IDX_BASE_LO);
   wire wr_irq = cfg_wr && (cfg.idx == ldio_pkg::IDX_IRQ);
   wire wr_dma = cfg_wr && (cfg.idx == ldio_pkg::IDX_DMA) && has_dma;
   // 75h, 76h-dfh, e0h-feh and ffh have no storage: no write enable exists
   logic [7:0] nxt_rdata; // read mux result
   logic [15:0] dec_hit; // per-device address match
   logic rst_any; // soft reset only; hardware reset acts asynchronously
   assign rst_any = soft_reset;
   // read mux: unlisted indexes read zero
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (cfg.idx)
         ldio_pkg::IDX_LDN: nxt_rdata = {4'h0, ldn_ff};
         ldio_pkg::IDX_ACT: nxt_rdata = {7'h00, act_ff[ldn_ff]};
         ldio_pkg::IDX_BASE_HI: nxt_rdata = base_hi_ff[ldn_ff];
         ldio_pkg::IDX_BASE_LO: nxt_rdata = base_lo_ff[ldn_ff];
         ldio_pkg::IDX_IRQ: nxt_rdata = irq_ff[ldn_ff];
         ldio_pkg::IDX_DMA: nxt_rdata = has_dma ? dma_ff[ldn_ff] : 8'h00;
         default: nxt_rdata = 8'h00;
      endcase
   end
   // ****************************************
   // device number register
   // ****************************************
   // ldn is global: writable in config state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ldn_ff <= 4'h0;
      end else if (rst_any) begin
         ldn_ff <= 4'h0;
      end else if (cfg_wr && cfg.idx == ldio_pkg::IDX_LDN) begin
         ldn_ff <= cfg.data[3:0];
      end
   end
   // read data holds until next read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_rdata_ff <= 8'h00;
      end else if (cfg_rd) begin
         cfg_rdata_ff <= nxt_rdata;
      end
   end
   // ****************************************
   // per-device registers and decoders
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < ldio_pkg::NUM_LD; g++) begin : g_ld
         localparam logic [3:0] LDG = 4'(g);
         // per-device reset defaults
         localparam logic [7:0] IRQ_RST = (g == 0) ? ldio_pkg::RST_IRQ_LD0
                                                   : ldio_pkg::RST_IRQ;
         localparam logic [7:0] DMA_RST = (g == 0) ? ldio_pkg::RST_DMA_LD0
                                : ((g == 3) || (g == 5)) ? ldio_pkg::RST_DMA_OTHER
                                : ldio_pkg::RST_ZERO;
         wire sel = (ldn_ff == LDG);
         // single bit serves both activate and power: they cannot diverge
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               act_ff[g] <= 1'b0;
               base_hi_ff[g] <= 8'h00;
               base_lo_ff[g] <= 8'h00;
               irq_ff[g] <= IRQ_RST;
               dma_ff[g] <= DMA_RST;
            end else if (rst_any) begin
               act_ff[g] <= 1'b0;
               base_hi_ff[g] <= 8'h00;
               base_lo_ff[g] <= 8'h00;
               irq_ff[g] <= IRQ_RST;
               dma_ff[g] <= DMA_RST;
            end else if (sel) begin
               if (wr_act) act_ff[g] <= cfg.data[ldio_pkg::ACT_BIT];
               if (wr_bhi) base_hi_ff[g] <= cfg.data;
               if (wr_blo) base_lo_ff[g] <= cfg.data;
               if (wr_irq) irq_ff[g] <= cfg.data;
               if (wr_dma) dma_ff[g] <= {5'h00, cfg.data[ldio_pkg::DMA_FIELD_W-1:0]};
            end
         end
         ldio_decode u_dec (
            .ld_num(LDG),
            .base({base_hi_ff[g], base_lo_ff[g]}),
            .active(act_ff[g]),
            .ecp_mode(ecp_mode),
            .qual16(qual16),
            .addr(io.addr),
            .base_ok(),
            .hit(dec_hit[g])
         );
      end
   endgenerate
   // ****************************************
   // registered outputs
   // ****************************************
   // claim only on an io cycle; invalid base already masked in decoder
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         io_claim_ff <= 16'h0000;
         dev_on_ff <= 16'h0000;
      end else begin
         io_claim_ff <= (io.rd || io.wr) ? dec_hit : 16'h0000;
         dev_on_ff <= act_ff;
      end
   end
   // ****************************************
   // checks
   // ****************************************
   AST_LDN_WRITE: assert property (@(posedge clk) disable iff (reset)
      (cfg_wr && cfg.idx == ldio_pkg::IDX_LDN && !rst_any) |=> ldn_ff == $past(cfg.data[3:0]))
      else $error("ldn not written");
   AST_NO_CFG_OUTSIDE: assert property (@(posedge clk) disable iff (reset)
      (!cfg_state && !rst_any) |=> $stable(ldn_ff))
      else $error("ldn changed outside config state");
   AST_DMA_RESET: assert property (@(posedge clk) disable iff (reset)
      rst_any |=> (dma_ff[0] == ldio_pkg::RST_DMA_LD0) && (dma_ff[3] == ldio_pkg::RST_DMA_OTHER))
      else $error("dma default wrong");
   AST_IRQ_RESET: assert property (@(posedge clk) disable iff (reset)
      rst_any |=> (irq_ff[0] == ldio_pkg::RST_IRQ_LD0) && (irq_ff[4] == 8'h00))
      else $error("irq default wrong");
   AST_RSVD_READ_ZERO: assert property (@(posedge clk) disable iff (reset)
      (cfg_rd && cfg.idx >= 8'h75) |=> cfg_rdata_ff == 8'h00)
      else $error("reserved index read nonzero");
   AST_DMA_ONLY_TWO: assert property (@(posedge clk) disable iff (reset)
      (cfg_rd && cfg.idx == ldio_pkg::IDX_DMA && !has_dma) |=> cfg_rdata_ff == 8'h00)
      else $error("dma select seen on wrong device");
   AST_ON_TRACKS: assert property (@(posedge clk) disable iff (reset)
      ##1 dev_on_ff == $past(act_ff))
      else $error("device on not tracking activate");
   AST_KBD_CLAIM: assert property (@(posedge clk) disable iff (reset)
      (io.rd && act_ff[7] && !qual16 && io.addr[11:0] == ldio_pkg::KBD_CMD_ADDR)
      |=> io_claim_ff[7])
      else $error("keyboard port not claimed");
   AST_NO_IDLE_CLAIM: assert property (@(posedge clk) disable iff (reset)
      (!io.rd && !io.wr) |=> io_claim_ff == 16'h0000)
      else $error("claim without io cycle");
   // ****************************************
   // multi-step checks
   // ****************************************
   // a taken write to the activate index of the selected bank
   sequence s_act_write;
      wr_act && !rst_any;
   endsequence
   // the bit lands in the bank next cycle and in the on flags a cycle later;
   // the bank number comes from the write cycle, so a following ldn write
   // cannot point this check at the wrong device
   sequence s_act_lands;
      ##1 (act_ff[$past(ldn_ff)] == $past(cfg.data[ldio_pkg::ACT_BIT]))
      ##1 (dev_on_ff[$past(ldn_ff, 2)] == $past(cfg.data[ldio_pkg::ACT_BIT], 2));
   endsequence
   AST_ACT_WRITE: assert property (@(posedge clk) disable iff (reset)
      s_act_write |-> s_act_lands)
      else $error("activate write not reflected in device on");
   // an io cycle whose upper address bits are set while qualification is on
   sequence s_unqualified_cycle;
      (io.rd || io.wr) && qual16 && (io.addr[15:12] != 4'h0);
   endsequence
   AST_QUAL16_BLOCK: assert property (@(posedge clk) disable iff (reset)
      s_unqualified_cycle |=> io_claim_ff == 16'h0000)
      else $error("claim on unqualified upper address");
   // soft reset must drop the bank number and every activate bit at once
   AST_SOFT_RESET_CLEARS: assert property (@(posedge clk) disable iff (reset)
      rst_any |=> (ldn_ff == 4'h0) && (act_ff == 16'h0000))
      else $error("soft reset left bank number or activate set");
   // a dma write to the serial 1 bank (4), which has no dma register, must store nothing
   AST_DMA_WRITE_DROP: assert property (@(posedge clk) disable iff (reset)
      (cfg_wr && cfg.idx == ldio_pkg::IDX_DMA && ldn_ff == ldio_pkg::LD_SER1 && !rst_any)
      |=> $stable(dma_ff[4]))
      else $error("dma select stored on a bank without one");
endmodule : ldio_bank

/* File: ldio_host.sv */
// ldio_host: behavioural host driving the configuration port and io cycles of the bank
module ldio_host (
   // clock
   input wire logic clk,
   // answers from the bank
   input wire logic [7:0] rdata,
   input wire logic [15:0] claim,
   // requests toward the bank
   output ldio_pkg::ldio_cfg_req_t cfg,
   output ldio_pkg::ldio_io_req_t io
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // idle state
   // ****************************************
   // strobes low from time zero so nothing is taken during reset
   initial begin
      cfg = '0;
      io = '0;
   end
   // ****************************************
   // bus tasks
   // ****************************************
   // one write strobe; bank number goes to index 07h first
   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      cfg <= '{wr: 1'b1, rd: 1'b0, idx: idx, data: d};
      @(posedge clk);
      // released lines show the inverse so stale values are never mistaken
      cfg <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~d};
   endtask : cfg_wr
   // one read strobe; data is registered at the taking edge
   task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
      @(posedge clk);
      cfg <= '{wr: 1'b0, rd: 1'b1, idx: idx, data: 8'h00};
      @(posedge clk);
      cfg <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: 8'hff};
      @(negedge clk);
      d = rdata;
   endtask : cfg_rd
   // one io read cycle; claim stands for the cycle after the sampling edge
   task automatic io_cyc(input logic [15:0] a, output logic [15:0] c);
      @(posedge clk);
      io <= '{rd: 1'b1, wr: 1'b0, addr: a};
      @(posedge clk);
      io <= '{rd: 1'b0, wr: 1'b0, addr: ~a};
      @(negedge clk);
      c = claim;
   endtask : io_cyc
endmodule : ldio_host

/* File: logical_device_io_decode_tb.sv */
// logical_device_io_decode_tb: self-checking bench for the configuration bank and decoder
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module logical_device_io_decode_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals and table
   // ****************************************
   typedef struct packed {
      logic [3:0] ld; // bank number
      logic wr;       // write before the read
      logic [7:0] idx;
      logic [7:0] d;
      logic [7:0] exp;
   } ldio_row_t;
   localparam ldio_row_t ROWS [16] = '{
      '{4'h0, 1'b0, 8'h70, 8'h00, 8'h06}, '{4'h4, 1'b0, 8'h70, 8'h00, 8'h00},
      '{4'h0, 1'b0, 8'h74, 8'h00, 8'h02}, '{4'h3, 1'b0, 8'h74, 8'h00, 8'h04},
      '{4'h0, 1'b1, 8'h74, 8'hfd, 8'h05}, '{4'h4, 1'b1, 8'h74, 8'h03, 8'h00},
      '{4'h0, 1'b1, 8'h75, 8'hff, 8'h00}, '{4'h0, 1'b1, 8'h76, 8'hff, 8'h00},
      '{4'h3, 1'b1, 8'ha8, 8'hff, 8'h00}, '{4'h0, 1'b1, 8'ha9, 8'hff, 8'h00},
      '{4'h0, 1'b1, 8'hdf, 8'hff, 8'h00}, '{4'h0, 1'b1, 8'he0, 8'hff, 8'h00},
      '{4'h0, 1'b1, 8'hfe, 8'hff, 8'h00}, '{4'h0, 1'b1, 8'hff, 8'hff, 8'h00},
      '{4'h4, 1'b1, 8'h60, 8'h03, 8'h03}, '{4'h4, 1'b1, 8'h61, 8'hf8, 8'hf8}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic soft_reset = 1'b0;
   logic cfg_state = 1'b1; // configuration state held open by default
   logic qual16 = 1'b0;
   logic ecp_mode = 1'b0;
   ldio_pkg::ldio_cfg_req_t cfg;
   ldio_pkg::ldio_io_req_t io;
   logic [7:0] cfg_rdata_ff;
   logic [3:0] ldn_ff;
   logic [15:0] dev_on_ff;
   logic [15:0] io_claim_ff;
   logic [7:0] rd;
   int n_mismatch = 0;
   int total_checks = 0;
   always #50 clk = ~clk; // 10 MHz
   ldio_bank DUT (.clk(clk), .reset(reset), .soft_reset(soft_reset), .cfg(cfg),
      .cfg_state(cfg_state), .qual16(qual16), .io(io), .ecp_mode(ecp_mode),
      .cfg_rdata_ff(cfg_rdata_ff), .ldn_ff(ldn_ff), .dev_on_ff(dev_on_ff),
      .io_claim_ff(io_claim_ff));
   ldio_host host (.clk(clk), .rdata(cfg_rdata_ff), .claim(io_claim_ff), .cfg(cfg), .io(io));
   // ****************************************
   // helpers
   // ****************************************
   // select a bank, program its base, activate it
   task automatic set_dev(input logic [3:0] ld, input logic [15:0] base);
      host.cfg_wr(ldio_pkg::IDX_LDN, {4'h0, ld});
      host.cfg_wr(ldio_pkg::IDX_BASE_HI, base[15:8]);
      host.cfg_wr(ldio_pkg::IDX_BASE_LO, base[7:0]);
      host.cfg_wr(ldio_pkg::IDX_ACT, 8'h01);
   endtask : set_dev
   // one io cycle, then compare the claim of one device
   task automatic claim(input logic [3:0] ld, input logic [15:0] a, input logic e);
      logic [15:0] c;
      logic [15:0] want; // only the named device may claim
      host.io_cyc(a, c);
      want = {15'h0000, e} << ld;
      `CHK(c, want)
   endtask : claim
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ****************************************
   // sequence
   // ****************************************
   // run is a few hundred cycles; the limit leaves a wide margin
   initial begin
      #1000000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK({dev_on_ff, io_claim_ff, ldn_ff}, 36'h0)
      // table rows: select bank, optional write, read back
      foreach (ROWS[i]) begin
         host.cfg_wr(ldio_pkg::IDX_LDN, {4'h0, ROWS[i].ld});
         if (ROWS[i].wr) begin
            host.cfg_wr(ROWS[i].idx, ROWS[i].d);
         end
         host.cfg_rd(ROWS[i].idx, rd);
         `CHK(rd, ROWS[i].exp)
      end
      `CHK(ldn_ff, 4'h4)
      set_dev(4'h4, 16'h03f8);
      repeat (2) @(negedge clk);
      `CHK(dev_on_ff, 16'h0010)
      claim(4'h4, 16'h03fa, 1'b1);
      claim(4'h4, 16'h03ff, 1'b1);
      claim(4'h4, 16'h0400, 1'b0);
      claim(4'h4, 16'h13fa, 1'b1);
      @(posedge clk) qual16 <= 1'b1;
      claim(4'h4, 16'h13fa, 1'b0);
      // qualification off again so the keyboard check sees an unqualified bus
      @(posedge clk) qual16 <= 1'b0;
      host.cfg_wr(ldio_pkg::IDX_ACT, 8'h00);
      claim(4'h4, 16'h03fa, 1'b0);
      set_dev(4'h5, 16'h0080);
      claim(4'h5, 16'h0080, 1'b0);
      set_dev(4'h7, 16'h0000);
      claim(4'h7, 16'h0060, 1'b1);
      claim(4'h7, 16'h0064, 1'b1);
      claim(4'h7, 16'h0062, 1'b0);
      set_dev(4'h3, 16'h0104);
      claim(4'h3, 16'h0106, 1'b1);
      claim(4'h3, 16'h0107, 1'b0);
      set_dev(4'h3, 16'h0108);
      claim(4'h3, 16'h010f, 1'b1);
      @(posedge clk) ecp_mode <= 1'b1;
      claim(4'h3, 16'h050a, 1'b1);
      claim(4'h3, 16'h050b, 1'b0);
      set_dev(4'h9, 16'h0123);
      claim(4'h9, 16'h0123, 1'b1);
      claim(4'h9, 16'h0124, 1'b0);
      // writes outside the configuration state must leave the bank alone
      @(posedge clk) cfg_state <= 1'b0;
      host.cfg_wr(ldio_pkg::IDX_LDN, 8'h00);
      @(posedge clk) cfg_state <= 1'b1;
      @(negedge clk);
      `CHK(ldn_ff, 4'h9)
      // soft reset reloads defaults, including the one rewritten above
      @(posedge clk) soft_reset <= 1'b1;
      @(posedge clk) soft_reset <= 1'b0;
      // on flags trail the activate bits by one cycle
      repeat (2) @(negedge clk);
      `CHK({dev_on_ff, ldn_ff}, 20'h0)
      host.cfg_rd(ldio_pkg::IDX_DMA, rd);
      `CHK(rd, 8'h02)
      report_and_stop();
   end
endmodule : logical_device_io_decode_tb
